//--- pkg/mode_reg_defines.vh
// Summary of operation
// - burst lengths two, four, eight, both orders
// - block chosen by column bits above offset
// - burst wraps inside its aligned block
// - one burst length for reads and writes
// - burst order bit picks sequential or interleaved
// - sequential start plus k, interleaved start xor k
// - read data appears latency clocks after command
// - read latency of 2, 2.5 or 3 clocks
// - operating bits all zero select normal mode
// - dll restart bit alone starts dll reset
// - extended register holds dll enable, drive strength
// - self refresh exit re-enables dll itself, except in a clock with an extended load, whose dll bit is taken instead
// - base register field layout as documented
// - base register retains, dll restart self-clears
`ifndef MODE_REG_DEFINES_VH
`define MODE_REG_DEFINES_VH
`define ADDR_W          14
`define COL_W           12
`define BL_LSB          0
`define BL_MSB          2
`define BT_BIT          3
`define CL_LSB          4
`define CL_MSB          6
`define OPM_LSB         7
`define OPM_MSB         13
`define DLL_RST_BIT     8
`define EMR_DLL_DIS_BIT 0
`define EMR_DRV_BIT     1
`define BL_2            3'h1
`define BL_4            3'h2
`define BL_8            3'h3
`define CL_2            3'h2
`define CL_3            3'h3
`define CL_25           3'h6
`define BT_SEQ          1'h0
`define MR_RESET        14'h0032
`define EMR_RESET       14'h0000
`define DLL_LOCK_CYC    8'hC8
`define LAT_SEL_W       3
`define LAT_SEL_2       3'h4
`define LAT_SEL_25      3'h5
`define LAT_SEL_3       3'h6
`endif

//--- rtl/burst_addr_gen.v
`timescale 1ns/1ps
`include "mode_reg_defines.vh"
// column for beat k of a burst inside its aligned block
module burst_addr_gen (
  input  wire [`COL_W-1:0] start_col_in, // column given with read or write
  input  wire [2:0]        beat_in,      // beat index k
  input  wire [2:0]        bl_code_in,   // burst length field
  input  wire              order_in,     // burst order bit
  output reg  [`COL_W-1:0] col_out       // column to access
);
  reg [2:0] mask;  // offset bits owned by the burst
  reg [2:0] off;   // start offset in block
  reg [2:0] step;  // offset for beat k
  always @* begin
    case (bl_code_in)
      `BL_2:   mask = 3'h1;
      `BL_4:   mask = 3'h3;
      `BL_8:   mask = 3'h7;
      default: mask = 3'h1; // reserved codes: treat as two
    endcase
    off = start_col_in[2:0] & mask;
    if (order_in == `BT_SEQ)
      step = (off + beat_in) & mask; // modulo via mask
    else
      step = (off ^ beat_in) & mask;
    // high bits kept, low bits replaced: burst wraps in block
    col_out = {start_col_in[`COL_W-1:3], (start_col_in[2:0] & ~mask) | step};
  end
endmodule

//--- rtl/mode_reg_burst.v
`timescale 1ns/1ps
`include "mode_reg_defines.vh"
// mode and extended mode registers, burst sequencer and read latency timing
module mode_reg_burst (
  input  wire                 clk_sys_in,        // command clock
  input  wire                 rst_in,            // sync active high reset
  input  wire                 load_mode_in,      // load mode register command
  input  wire                 bank_select_low_in, // bank select 0
  input  wire                 bank_select_high_in, // bank select 1
  input  wire [`ADDR_W-1:0]   addr_in,           // op-code or column
  input  wire                 read_cmd_in,       // read command
  input  wire                 write_cmd_in,      // write command
  input  wire                 self_refresh_exit_in, // self refresh exit pulse
  input  wire                 clk_gate_in,       // clock-gate level (cke)
  output reg  [2:0]           burst_len_code_out, // stored burst length
  output reg                  burst_order_select_bit_out, // stored order
  output reg  [2:0]           read_latency_setting_out, // stored latency
  output reg                  dll_restart_bit_out, // dll restart requested, high for one clock
  output reg                  normal_mode_out,   // last load was normal
  output reg                  dll_enable_out,    // dll enabled
  output reg                  drive_weak_out,    // reduced drive strength
  output reg                  dll_locked_out,    // 200 clocks passed
  output reg                  burst_active_out,  // burst beats running
  output reg                  burst_is_write_out, // current burst is write
  output reg  [`COL_W-1:0]    burst_col_out,     // column of current beat
  output reg                  rd_data_valid_out, // first read data edge
  output reg                  rd_half_cycle_out  // data on falling edge
);
  localparam ST_IDLE = 2'h1; // no burst
  localparam ST_RUN  = 2'h2; // stepping beats

  reg [1:0]         state_r;    // burst state, one-hot
  reg [`COL_W-1:0]  start_r;    // start column
  reg [2:0]         beat_r;     // beat index
  reg [2:0]         last_beat;  // final beat index
  reg [7:0]         lock_cnt_r; // dll relock counter
  reg [`LAT_SEL_W-1:0] lat_pipe_r; // read latency shift chain
  wire [`COL_W-1:0] gen_col;    // column from generator
  wire              mr_sel;     // base register selected
  wire              emr_sel;    // extended register selected
  wire [6:0]        opm;        // operating mode bits

  assign mr_sel  = load_mode_in & ~bank_select_low_in & ~bank_select_high_in;
  assign emr_sel = load_mode_in & bank_select_low_in & ~bank_select_high_in;
  assign opm     = addr_in[`OPM_MSB:`OPM_LSB];

  // beats per burst minus one from the single length field
  always @* begin
    case (burst_len_code_out)
      `BL_4:   last_beat = 3'h3;
      `BL_8:   last_beat = 3'h7;
      default: last_beat = 3'h1;
    endcase
  end

  burst_addr_gen u_gen (
    .start_col_in (start_r),
    .beat_in      (beat_r),
    .bl_code_in   (burst_len_code_out),
    .order_in     (burst_order_select_bit_out),
    .col_out      (gen_col)
  );

  // base and extended mode registers
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      burst_len_code_out         <= `BL_4; // length field of the reset op-code
      burst_order_select_bit_out <= 1'h0;
      read_latency_setting_out   <= `CL_3;
      dll_restart_bit_out        <= 1'h0;
      normal_mode_out            <= 1'h1;
      dll_enable_out             <= 1'h1;
      drive_weak_out             <= 1'h0;
    end else begin
      // restart flag clears itself one clock after its load
      dll_restart_bit_out <= 1'h0;
      if (mr_sel) begin
        burst_len_code_out         <= addr_in[`BL_MSB:`BL_LSB];
        burst_order_select_bit_out <= addr_in[`BT_BIT];
        read_latency_setting_out   <= addr_in[`CL_MSB:`CL_LSB];
        normal_mode_out  <= (opm == 7'h00);
        dll_restart_bit_out <= (opm == 7'h02);
      end
      if (emr_sel) begin
        dll_enable_out <= ~addr_in[`EMR_DLL_DIS_BIT];
        drive_weak_out <= addr_in[`EMR_DRV_BIT];
      end else if (self_refresh_exit_in) begin
        dll_enable_out <= 1'h1; // automatic re-enable
      end
    end
  end

  // dll lock wait: clocks counted only with clock gate high
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      lock_cnt_r     <= 8'h00;
      dll_locked_out <= 1'h0;
    end else if (dll_restart_bit_out || self_refresh_exit_in ||
                 (emr_sel && !addr_in[`EMR_DLL_DIS_BIT]) || !dll_enable_out) begin
      lock_cnt_r     <= 8'h00; // restart wait on any enable or reset
      dll_locked_out <= 1'h0;
    end else if (clk_gate_in && !dll_locked_out) begin
      lock_cnt_r <= lock_cnt_r + 8'h01;
      if (lock_cnt_r == `DLL_LOCK_CYC - 8'h01)
        dll_locked_out <= 1'h1; // status only, reads are not blocked
    end
  end

  // burst sequencer; a new command restarts the burst (truncation)
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_r            <= ST_IDLE;
      start_r            <= {`COL_W{1'b0}};
      beat_r             <= 3'h0;
      burst_active_out   <= 1'h0;
      burst_is_write_out <= 1'h0;
      burst_col_out      <= {`COL_W{1'b0}};
    end else begin
      if (read_cmd_in || write_cmd_in) begin
        state_r            <= ST_RUN;
        start_r            <= addr_in[`COL_W-1:0];
        beat_r             <= 3'h0;
        burst_is_write_out <= write_cmd_in;
        burst_active_out   <= 1'h0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            burst_active_out <= 1'h0;
          end
          ST_RUN: begin
            burst_active_out <= 1'h1;
            burst_col_out    <= gen_col;
            if (beat_r == last_beat)
              state_r <= ST_IDLE; // same length for both directions
            else
              beat_r <= beat_r + 3'h1;
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // read latency: command at edge n, data flag at edge n+m
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      lat_pipe_r        <= {`LAT_SEL_W{1'b0}};
      rd_data_valid_out <= 1'h0;
      rd_half_cycle_out <= 1'h0;
    end else begin
      lat_pipe_r <= {lat_pipe_r[`LAT_SEL_W-2:0], read_cmd_in};
      case (read_latency_setting_out)
        `CL_2: begin
          rd_data_valid_out <= lat_pipe_r[0];
          rd_half_cycle_out <= 1'h0;
        end
        `CL_25: begin
          // half clock falls after edge n+2; flag marks that edge
          rd_data_valid_out <= lat_pipe_r[0];
          rd_half_cycle_out <= lat_pipe_r[0];
        end
        default: begin
          rd_data_valid_out <= lat_pipe_r[1]; // three clocks, also for reserved
          rd_half_cycle_out <= 1'h0;
        end
      endcase
    end
  end
endmodule

//--- sim/ddr_ctrl_model.sv
`timescale 1ns/1ps
// controller side: one command per call, raised and dropped on falling edges
module ddr_ctrl_model (
  input  wire        clk_sys_in,
  output reg  [3:0]  cmd_out,      // load, read, write, self refresh exit
  output reg  [1:0]  bank_sel_out, // high then low bank select
  output reg  [13:0] addr_out,     // op-code or column
  output reg         clk_gate_out  // held high so the lock wait runs
);
  // idle bus, clock gate on from the start
  initial {cmd_out, bank_sel_out, addr_out, clk_gate_out} = 21'h000001;
  // callers only use selects 00 and 01 and legal op-codes
  task issue(input [1:0] kind, input [1:0] bs, input [13:0] a);
    begin
      @(negedge clk_sys_in);
      cmd_out = 4'h8 >> kind;
      bank_sel_out = bs;
      addr_out = a;
      @(negedge clk_sys_in);
      cmd_out = 4'h0;
      addr_out = ~a; // a released bus must not keep the last op-code
    end
  endtask
endmodule

//--- sim/mode_reg_burst_asserts.sv
`timescale 1ns/1ps
`include "mode_reg_defines.vh"
// port-level checks of the mode register block
module mode_reg_burst_asserts (
  input wire        clk_sys_in,
  input wire        rst_in,
  input wire        load_mode_in,
  input wire        bank_select_low_in,
  input wire        bank_select_high_in,
  input wire [13:0] addr_in,
  input wire        read_cmd_in,
  input wire        write_cmd_in,
  input wire        self_refresh_exit_in,
  input wire [2:0]  burst_len_code_out,
  input wire [2:0]  read_latency_setting_out,
  input wire        dll_restart_bit_out,
  input wire        normal_mode_out,
  input wire        dll_enable_out,
  input wire        burst_active_out,
  input wire [11:0] burst_col_out,
  input wire        rd_data_valid_out,
  input wire        rd_half_cycle_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // loads aimed at the base and the extended register
  wire base_ld = load_mode_in & ~bank_select_low_in & ~bank_select_high_in;
  wire ext_ld = load_mode_in & bank_select_low_in & ~bank_select_high_in;
  wire [2:0] cl = read_latency_setting_out;
  fields_load_a: assert property (
    base_ld |=> {burst_len_code_out, cl} == $past({addr_in[2:0], addr_in[6:4]}))
    else $error("fields not loaded");
  normal_load_a: assert property (
    base_ld && addr_in[13:7] == 7'h00 |=> normal_mode_out) else $error("not normal");
  restart_pulse_a: assert property (
    base_ld && addr_in[13:7] == 7'h02 |=> dll_restart_bit_out ##1 !dll_restart_bit_out)
    else $error("restart not a pulse");
  ext_load_a: assert property (
    ext_ld |=> dll_enable_out == !$past(addr_in[0]) && $stable(burst_len_code_out))
    else $error("extended load wrong");
  cl3_data_a: assert property (
    read_cmd_in && cl == `CL_3 |-> ##3 rd_data_valid_out) else $error("late data");
  short_cl_a: assert property (
    read_cmd_in && (cl == `CL_2 || cl == `CL_25) |-> ##2 rd_data_valid_out
    && rd_half_cycle_out == ($past(cl, 2) == `CL_25)) else $error("short latency");
  burst_start_a: assert property (
    write_cmd_in |-> ##2 burst_active_out && burst_col_out == $past(addr_in[11:0], 2))
    else $error("bad first beat");
  refresh_exit_a: assert property (
    self_refresh_exit_in |=> dll_enable_out) else $error("dll still off");
endmodule
bind mode_reg_burst mode_reg_burst_asserts mode_reg_burst_asserts_i (.*);

//--- sim/mode_reg_burst_bench.sv
`timescale 1ns/1ps
`include "mode_reg_defines.vh"
module mode_reg_burst_bench;
  reg clk_sys_in = 1'b0; // 10 MHz command clock
  reg rst_in = 1'b1;     // held over the first three edges
  integer n_errors = 0, checks_done = 0, seed = 32'hb65d, i, j, k, n;
  reg [11:0] col;        // random burst start column
  wire load_mode_in, bank_select_low_in, bank_select_high_in, read_cmd_in, write_cmd_in;
  wire self_refresh_exit_in, clk_gate_in, burst_order_select_bit_out, dll_restart_bit_out;
  wire normal_mode_out, dll_enable_out, drive_weak_out, dll_locked_out, burst_active_out;
  wire burst_is_write_out, rd_data_valid_out, rd_half_cycle_out;
  wire [13:0] addr_in;
  wire [11:0] burst_col_out;
  wire [2:0] burst_len_code_out, read_latency_setting_out;
  always #50 clk_sys_in = ~clk_sys_in;
  mode_reg_burst mode_reg_burst_i (.*);
  ddr_ctrl_model ddr_ctrl_model_i (.clk_sys_in(clk_sys_in), .addr_out(addr_in),
    .cmd_out({load_mode_in, read_cmd_in, write_cmd_in, self_refresh_exit_in}),
    .bank_sel_out({bank_select_high_in, bank_select_low_in}), .clk_gate_out(clk_gate_in));
  // one compare, counted; x or z never matches
  task check(input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // beat k stays in the aligned block: offset wraps, block bits never move
  function [11:0] exp_col(input [11:0] s, input [3:0] k, input [3:0] len, input o);
    exp_col = (s & ~(len - 12'h001)) | ((o ? (s ^ k) : (s + k)) & (len - 12'h001));
  endfunction
  initial begin
    repeat (3) @(negedge clk_sys_in);
    rst_in = 1'b0;
    // power-up order: dll on, restart, back to normal
    ddr_ctrl_model_i.issue(2'h0, 2'h1, 14'h0000);
    check({dll_enable_out, drive_weak_out}, 2'h2);
    ddr_ctrl_model_i.issue(2'h0, 2'h0, 14'h0132);
    check({dll_restart_bit_out, normal_mode_out}, 2'h2);
    @(negedge clk_sys_in);
    check(dll_restart_bit_out, 0);
    ddr_ctrl_model_i.issue(2'h0, 2'h0, 14'h0032);
    check(normal_mode_out, 1);
    for (n = 0; n < 300 && !dll_locked_out; n = n + 1) @(negedge clk_sys_in);
    check(n >= 190 && n <= 200, 1); // no read before the lock wait
    $display("init done");
    // every length and order, one read and one write each from a random start
    for (i = 0; i < 6; i = i + 1) begin
      ddr_ctrl_model_i.issue(2'h0, 2'h0, {7'h00, `CL_3, i[0], i[2:1] + 3'h1});
      check({burst_len_code_out, burst_order_select_bit_out}, {i[2:1] + 3'h1, i[0]});
      for (j = 0; j < 2; j = j + 1) begin
        col = $random(seed);
        ddr_ctrl_model_i.issue(2'h1 + j[1:0], 2'h0, {2'h0, col});
        for (n = 0; n < 5 && !burst_active_out; n = n + 1) @(negedge clk_sys_in);
        check(n < 5, 1); // burst must start within the bound
        check(burst_is_write_out, j);
        for (k = 0; k < (2 << i[2:1]); k = k + 1) begin
          check(burst_col_out, exp_col(col, k, 2 << i[2:1], i[0]));
          @(negedge clk_sys_in);
        end
        check(burst_active_out, 0);
      end
    end
    $display("bursts done");
    // each latency code: cycles to first data and the half-cycle flag
    // the flag is registered one edge before edge n+m, so it is seen m-1 falling edges on
    for (i = 0; i < 3; i = i + 1) begin
      ddr_ctrl_model_i.issue(2'h0, 2'h0, {7'h00, i == 0 ? `CL_2 : i == 1 ? `CL_25 : `CL_3,
        1'b0, `BL_8});
      ddr_ctrl_model_i.issue(2'h1, 2'h0, 14'h0000);
      for (n = 0; n < 6 && !rd_data_valid_out; n = n + 1) @(negedge clk_sys_in);
      check({n[3:0], rd_half_cycle_out}, {i == 2 ? 4'h2 : 4'h1, i == 1});
    end
    $display("latency done");
    // extended load during the last read burst: dll off, weak drive, base fields kept
    ddr_ctrl_model_i.issue(2'h0, 2'h1, 14'h0003);
    check({dll_enable_out, drive_weak_out, burst_len_code_out}, {2'h1, `BL_8});
    ddr_ctrl_model_i.issue(2'h3, 2'h0, 14'h0000);
    check(dll_enable_out, 1);
    $display("dll done");
    give_verdict;
  end
endmodule
